// File: src/sfs_pkg.sv
// Package with constants for the frame status queue.
// Behaviour
// - Ten-entry nineteen-bit queue, separate from data queue.
// - Entry holds 14-bit count plus five status.
// - Queue active only when enabled and bit-sync mode.
// - Pointers clear when disabled or on reset.
// - Reset clears the queue enable bit.
// - Disabled: upper four addresses alias lower four.
// - Frame count registers readable only when enabled.
// - Extended readback bit two shows queue enable.
// - Enabled non-empty reads return the oldest entry.
// - Status read at SFS_OFF_SPECIAL pops one entry, its alias none; never underflows.
// - Empty queue delivers live status, blocks underflow.
// - Upper count bit six flags queued status.
// - Only residue, overrun, CRC error are queued.
// - End of frame writes entry, advances pointer.
// - Overflow sets bit seven; toggling enable clears.
// - Abort still loads count, then clears counter.
// - CRC checker resets after closing flag.
package sfs_pkg;
  localparam int SFS_DEPTH = 10;
  localparam int SFS_CNT_W = 14;
  localparam int SFS_STAT_W = 5;
  localparam int SFS_ENTRY_W = 19;
  localparam int SFS_PTR_W = 4;
  // Register byte offsets on APB, one word per register index.
  localparam logic [5:0] SFS_OFF_PRIMARY = 6'h00;
  localparam logic [5:0] SFS_OFF_SPECIAL = 6'h04;
  localparam logic [5:0] SFS_OFF_VECTOR = 6'h08;
  localparam logic [5:0] SFS_OFF_PENDING = 6'h0C;
  localparam logic [5:0] SFS_OFF_ALIAS_PRI = 6'h10;
  localparam logic [5:0] SFS_OFF_ALIAS_SPEC = 6'h14;
  localparam logic [5:0] SFS_OFF_FC_LOW = 6'h18;
  localparam logic [5:0] SFS_OFF_FC_HIGH = 6'h1C;
  localparam logic [5:0] SFS_OFF_EXT_CTRL = 6'h3C;
  localparam logic [5:0] SFS_OFF_EXT_STAT = 6'h3C;
  localparam logic [5:0] SFS_OFF_MODE = 6'h20;
  // Field positions.
  localparam int SFS_BIT_QEN = 2;
  localparam int SFS_BIT_AVAIL = 6;
  localparam int SFS_BIT_OVF = 7;
  localparam int SFS_BIT_ALLSENT = 0;
  localparam int SFS_BIT_RES_LO = 1;
  localparam int SFS_BIT_PARITY = 4;
  localparam int SFS_BIT_OVR = 5;
  localparam int SFS_BIT_CRC = 6;
  localparam int SFS_BIT_EOF = 7;
  localparam logic [7:0] SFS_EXT_CTRL_RST = 8'h00;
  localparam logic [7:0] SFS_CRC_PRESET = 8'hFF;
  typedef enum logic [2:0] {
    SFS_ST_IDLE = 3'b001,
    SFS_ST_SETUP = 3'b010,
    SFS_ST_ACCESS = 3'b100
  } sfs_apb_st_t;
endpackage

// File: src/sfs_queue.sv
// Ten-entry frame status queue with guarded pop and sticky overflow.
`timescale 1ns/100ps
module sfs_queue
#(
  parameter int DEPTH = sfs_pkg::SFS_DEPTH,
  parameter int WIDTH = sfs_pkg::SFS_ENTRY_W
)
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // Control.
  input wire logic active,
  input wire logic push,
  input wire logic [WIDTH-1:0] push_data,
  input wire logic pop,
  // State.
  output logic [WIDTH-1:0] head_data,
  output logic empty,
  output logic overflow
);
  import sfs_pkg::*;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [SFS_PTR_W-1:0] wr_ptr_r;
  logic [SFS_PTR_W-1:0] rd_ptr_r;
  logic [SFS_PTR_W:0] count_r;
  logic ovf_r;
  wire full = (count_r == (SFS_PTR_W+1)'(DEPTH));
  wire do_push = active && push && !full;
  wire do_pop = active && pop && (count_r != '0);

  function automatic logic [SFS_PTR_W-1:0] ptr_inc(input logic [SFS_PTR_W-1:0] p);
    ptr_inc = (p == SFS_PTR_W'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  always_ff @(posedge core_clk)
  begin
    if (!rst_n || !active)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
      ovf_r <= 1'b0;
    end
    else
    begin
      if (do_push)
        wr_ptr_r <= ptr_inc(wr_ptr_r);
      if (do_pop)
        rd_ptr_r <= ptr_inc(rd_ptr_r);
      count_r <= count_r + (SFS_PTR_W+1)'(do_push) - (SFS_PTR_W+1)'(do_pop);
      if (push && full)
        ovf_r <= 1'b1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (do_push)
      mem[wr_ptr_r] <= push_data;
  end

  assign head_data = mem[rd_ptr_r];
  assign empty = (count_r == '0);
  assign overflow = ovf_r;
endmodule // sfs_queue

// File: src/sfs_counter.sv
// Received byte counter and CRC checker state for one frame.
`timescale 1ns/100ps
module sfs_counter
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // Receive events.
  input wire logic rx_byte,
  input wire logic rx_crc_bit_vld,
  input wire logic rx_crc_bit,
  input wire logic frame_end,
  // Results.
  output logic [sfs_pkg::SFS_CNT_W-1:0] byte_count,
  output logic [15:0] crc_state
);
  import sfs_pkg::*;
  logic [SFS_CNT_W-1:0] cnt_r;
  logic [15:0] crc_r;
  wire fb = crc_r[15] ^ rx_crc_bit;
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || frame_end)
    begin
      cnt_r <= '0;
      crc_r <= {SFS_CRC_PRESET, SFS_CRC_PRESET};
    end
    else
    begin
      if (rx_byte)
        cnt_r <= cnt_r + 1'b1;
      if (rx_crc_bit_vld)
        crc_r <= {crc_r[14:0], 1'b0} ^ (fb ? 16'h1021 : 16'h0000);
    end
  end
  assign byte_count = cnt_r;
  assign crc_state = crc_r;
endmodule // sfs_counter

// File: src/sdlc_frame_status_fifo.sv
// Frame status queue top level with APB register slave.
`timescale 1ns/100ps
module sdlc_frame_status_fifo
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Receiver side.
  input wire logic rx_byte,
  input wire logic rx_crc_bit_vld,
  input wire logic rx_crc_bit,
  input wire logic rx_eof,
  input wire logic rx_abort,
  input wire logic [2:0] rx_residue,
  input wire logic rx_overrun,
  input wire logic rx_parity_err,
  input wire logic rx_all_sent,
  // Other channel status for the low registers.
  input wire logic [7:0] primary_status,
  input wire logic [7:0] vector_readback,
  input wire logic [7:0] pending_readback,
  // Observability.
  output logic [15:0] crc_residual,
  output logic queue_active
);
  import sfs_pkg::*;

  logic [7:0] ext_ctrl_r;
  logic sdlc_mode_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic pop_armed_r;
  logic [SFS_CNT_W-1:0] byte_count;
  logic [SFS_ENTRY_W-1:0] head_data;
  logic q_empty;
  logic q_overflow;

  wire q_en = ext_ctrl_r[SFS_BIT_QEN];
  wire active = q_en && sdlc_mode_r;
  wire frame_end = rx_eof || rx_abort;
  wire crc_err = (crc_residual != 16'h1D0F) && rx_eof;
  // Only residue, overrun and CRC error travel through the queue.
  wire [SFS_STAT_W-1:0] live_q_bits = {crc_err, rx_overrun, rx_residue};
  wire [SFS_ENTRY_W-1:0] push_data = {live_q_bits, byte_count};
  wire from_queue = active && !q_empty;

  wire [SFS_STAT_W-1:0] sel_q_bits = from_queue ? head_data[SFS_ENTRY_W-1:SFS_CNT_W] : live_q_bits;
  wire [SFS_CNT_W-1:0] sel_count = from_queue ? head_data[SFS_CNT_W-1:0] : byte_count;
  wire [7:0] special_status = {rx_eof, sel_q_bits[4], sel_q_bits[3], rx_parity_err,
                               sel_q_bits[2:0], rx_all_sent};
  wire [7:0] fc_low = sel_count[7:0];
  wire [7:0] fc_high = {q_overflow, from_queue, sel_count[SFS_CNT_W-1:8]};
  wire [7:0] ext_stat = {ext_ctrl_r[7:3], q_en, ext_ctrl_r[1:0]};

  wire [5:0] addr = paddr[5:0];
  wire acc = psel && penable;
  wire rd_acc = acc && !pwrite;
  wire wr_acc = acc && pwrite;
  wire hit_pri = (addr == SFS_OFF_PRIMARY);
  wire hit_spec = (addr == SFS_OFF_SPECIAL);
  wire hit_vec = (addr == SFS_OFF_VECTOR);
  wire hit_pend = (addr == SFS_OFF_PENDING);
  wire hit_apri = (addr == SFS_OFF_ALIAS_PRI);
  wire hit_aspec = (addr == SFS_OFF_ALIAS_SPEC);
  wire hit_fcl = (addr == SFS_OFF_FC_LOW);
  wire hit_fch = (addr == SFS_OFF_FC_HIGH);
  wire hit_ext = (addr == SFS_OFF_EXT_CTRL);
  wire hit_mode = (addr == SFS_OFF_MODE);
  wire addr_ok = (paddr[31:6] == '0) && (hit_pri || hit_spec || hit_vec || hit_pend || hit_apri
                 || hit_aspec || hit_fcl || hit_fch || hit_ext || hit_mode);
  // Only a read at the special status offset pops; its alias never does.
  wire rd_pop_req = !pwrite && addr_ok && hit_spec && from_queue;
  wire pop = rd_acc && pop_armed_r;

  logic [7:0] rd_byte;
  always_comb
  begin
    rd_byte = 8'h00;
    if (hit_pri)
      rd_byte = primary_status;
    else if (hit_spec)
      rd_byte = special_status;
    else if (hit_vec)
      rd_byte = vector_readback;
    else if (hit_pend)
      rd_byte = pending_readback;
    else if (hit_apri)
      rd_byte = primary_status;
    else if (hit_aspec)
      rd_byte = special_status;
    else if (hit_fcl)
      rd_byte = q_en ? fc_low : vector_readback;
    else if (hit_fch)
      rd_byte = q_en ? fc_high : pending_readback;
    else if (hit_ext)
      rd_byte = ext_stat;
    else if (hit_mode)
      rd_byte = {7'h00, sdlc_mode_r};
  end

  // Read data is taken at the end of setup so that prdata comes from a flop.
  // The pop is armed only when that snapshot came from the queue, so an entry
  // pushed into an empty queue during setup is never released unread.
  wire [31:0] rd_word = (!pwrite && addr_ok) ? {24'h000000, rd_byte} : 32'h0000_0000;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      ext_ctrl_r <= SFS_EXT_CTRL_RST;
      sdlc_mode_r <= 1'b0;
    end
    else if (wr_acc && addr_ok)
    begin
      if (hit_ext)
        ext_ctrl_r <= pwdata[7:0];
      else if (hit_mode)
        sdlc_mode_r <= pwdata[0];
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
      pop_armed_r <= 1'b0;
    end
    else if (psel && !penable)
    begin
      prdata_r <= rd_word;
      pslverr_r <= !addr_ok;
      pop_armed_r <= rd_pop_req;
    end
    else
    begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
      pop_armed_r <= 1'b0;
    end
  end

  // Zero wait states: the word taken at the end of setup stands through the access cycle.
  assign pready = 1'b1;
  assign prdata = prdata_r;
  assign pslverr = acc && pslverr_r;

  sfs_counter u_counter (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .rx_byte(rx_byte),
    .rx_crc_bit_vld(rx_crc_bit_vld),
    .rx_crc_bit(rx_crc_bit),
    .frame_end(frame_end),
    .byte_count(byte_count),
    .crc_state(crc_residual)
  );

  sfs_queue #(
    .DEPTH(SFS_DEPTH),
    .WIDTH(SFS_ENTRY_W)
  ) u_queue (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .active(active),
    .push(frame_end),
    .push_data(push_data),
    .pop(pop),
    .head_data(head_data),
    .empty(q_empty),
    .overflow(q_overflow)
  );

  assign queue_active = active;
endmodule // sdlc_frame_status_fifo

// File: tb/sfs_assertions.sv
// Checker for the frame status queue ports.
`timescale 1ns/100ps
module sfs_assertions
  import sfs_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // APB.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  // Receiver and status.
  input wire logic rx_eof,
  input wire logic rx_abort,
  input wire logic [7:0] primary_status,
  input wire logic [7:0] vector_readback,
  input wire logic [7:0] pending_readback,
  input wire logic [15:0] crc_residual,
  input wire logic queue_active
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_rd(a);
    psel && penable && !pwrite && paddr[31:6] == 26'h0 && paddr[5:0] == a;
  endsequence
  property p_rst_off; disable iff (1'b0) !rst_n |=> !queue_active; endproperty
  a_rst_off: assert property (p_rst_off) else $error("queue active after reset");
  property p_ext; s_rd(SFS_OFF_EXT_STAT) |-> prdata[2] == queue_active; endproperty
  a_ext: assert property (p_ext) else $error("enable readback wrong");
  property p_alias; s_rd(SFS_OFF_ALIAS_PRI) |-> prdata[7:0] == primary_status; endproperty
  a_alias: assert property (p_alias) else $error("alias of primary wrong");
  property p_fc_lo; s_rd(SFS_OFF_FC_LOW) ##0 !queue_active |-> prdata[7:0] == vector_readback; endproperty
  a_fc_lo: assert property (p_fc_lo) else $error("count low readable while off");
  property p_fc_hi; s_rd(SFS_OFF_FC_HIGH) ##0 !queue_active |-> prdata[7:0] == pending_readback; endproperty
  a_fc_hi: assert property (p_fc_hi) else $error("count high alias wrong");
  property p_crc; rx_eof || rx_abort |=> crc_residual == 16'hFFFF; endproperty
  a_crc: assert property (p_crc) else $error("checker not preset after frame");
  property p_dis; psel && penable && pwrite && paddr == 32'h3C && !pwdata[2] |=> (!queue_active)[*2]; endproperty
  a_dis: assert property (p_dis) else $error("queue still active when off");
  property p_ready; psel && penable |-> pready && prdata[31:8] == 24'h0; endproperty
  a_ready: assert property (p_ready) else $error("access not answered at once");
endmodule // sfs_assertions

// File: tb/sfs_host.sv
// Host model: APB master that reads and writes the channel registers.
`timescale 1ns/100ps
module sfs_host
(
  // Clock.
  input wire logic core_clk,
  // APB master.
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
  end
  // Holds the request until pready is seen high, then takes the answer.
  task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] q, output logic e);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1)
      @(posedge core_clk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule // sfs_host

// File: tb/sdlc_frame_status_fifo_bench.sv
// Self-checking bench for the frame status queue.
`timescale 1ns/100ps
module sdlc_frame_status_fifo_bench;
  import sfs_pkg::*;
  logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr, queue_active, err;
  logic rx_byte, rx_crc_bit_vld, rx_crc_bit, rx_eof, rx_abort, rx_overrun, rx_parity_err, rx_all_sent;
  logic [2:0] rx_residue;
  logic [7:0] primary_status, vector_readback, pending_readback;
  logic [15:0] crc_residual;
  logic [31:0] paddr, pwdata, prdata, q;
  int n_mismatch, check_count, n;
  sdlc_frame_status_fifo uut (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .rx_byte, .rx_crc_bit_vld, .rx_crc_bit, .rx_eof, .rx_abort, .rx_residue,
    .rx_overrun, .rx_parity_err, .rx_all_sent, .primary_status, .vector_readback, .pending_readback,
    .crc_residual, .queue_active);
  sfs_host host (.core_clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, e);
    check_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] m, e);
    host.xfer(1'b0, {26'h0, a}, 32'h0, q, err);
    cmp(q & {24'h0, m}, {24'h0, e});
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    host.xfer(1'b1, {26'h0, a}, {24'h0, d}, q, err);
  endtask
  // Frame i carries i*40+1 bytes; frame 3 ends in an abort.
  task automatic frame(input int i);
    rx_residue <= i[2:0];
    rx_overrun <= i[0];
    repeat (i * 40 + 1)
    begin
      @(posedge core_clk);
      rx_byte <= 1'b1;
      rx_crc_bit_vld <= 1'b1;
      rx_crc_bit <= ~rx_crc_bit;
      @(posedge core_clk);
      rx_byte <= 1'b0;
      rx_crc_bit_vld <= 1'b0;
    end
    rx_eof <= i != 3;
    rx_abort <= i == 3;
    @(posedge core_clk);
    rx_eof <= 1'b0;
    rx_abort <= 1'b0;
    @(posedge core_clk);
    cmp({16'h0, crc_residual}, 32'hFFFF);
  endtask
  initial
  begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    close_out;
  end
  initial
  begin
    {rst_n, rx_byte, rx_crc_bit_vld, rx_crc_bit, rx_eof, rx_abort, rx_overrun, rx_parity_err} = 8'h0;
    rx_all_sent = 1'b1;
    rx_residue = 3'h0;
    primary_status = 8'hA5;
    vector_readback = 8'h3C;
    pending_readback = 8'h5A;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(SFS_OFF_EXT_STAT, 8'h04, 8'h00);
    rd(SFS_OFF_ALIAS_PRI, 8'hFF, 8'hA5);
    rd(SFS_OFF_FC_LOW, 8'hFF, 8'h3C);
    rd(SFS_OFF_FC_HIGH, 8'hFF, 8'h5A);
    rd(SFS_OFF_ALIAS_SPEC, 8'hFF, 8'h01);
    frame(1);
    wr(SFS_OFF_MODE, 8'h01);
    rd(SFS_OFF_MODE, 8'h01, 8'h01);
    wr(SFS_OFF_EXT_CTRL, 8'h04);
    rd(SFS_OFF_EXT_STAT, 8'h04, 8'h04);
    rd(SFS_OFF_FC_HIGH, 8'h40, 8'h00);
    for (int i = 0; i < 11; i++)
      frame(i);
    rx_residue <= 3'h7;
    rx_overrun <= 1'b0;
    for (int i = 0; i < 10; i++)
    begin
      n = i * 40 + 1;
      rd(SFS_OFF_FC_LOW, 8'hFF, n[7:0]);
      rd(SFS_OFF_FC_HIGH, 8'hFF, {2'b11, n[13:8]});
      rd(SFS_OFF_SPECIAL, 8'h3F, {2'b0, i[0], 1'b0, i[2:0], 1'b1});
    end
    rd(SFS_OFF_FC_HIGH, 8'h40, 8'h00);
    rd(SFS_OFF_SPECIAL, 8'h3F, 8'h0F);
    rd(SFS_OFF_SPECIAL, 8'h3F, 8'h0F);
    frame(5);
    rd(SFS_OFF_ALIAS_SPEC, 8'h3F, 8'h2B);
    rd(SFS_OFF_FC_LOW, 8'hFF, 8'hC9);
    rd(SFS_OFF_FC_HIGH, 8'hC0, 8'hC0);
    wr(SFS_OFF_EXT_CTRL, 8'h00);
    rd(SFS_OFF_EXT_STAT, 8'h04, 8'h00);
    wr(SFS_OFF_EXT_CTRL, 8'h04);
    rd(SFS_OFF_FC_HIGH, 8'hC0, 8'h00);
    host.xfer(1'b0, 32'h40, 32'h0, q, err);
    cmp({31'h0, err}, 32'h1);
    cmp(q, 32'h0);
    close_out;
  end
endmodule // sdlc_frame_status_fifo_bench
bind sdlc_frame_status_fifo sfs_assertions chk (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .rx_eof, .rx_abort, .primary_status, .vector_readback, .pending_readback,
  .crc_residual, .queue_active);
